// [src/lss_fdec.sv]
`timescale 1ns/10ps
module lss_fdec #(
    parameter int N = lss_pkg::N_IN
) (
    input wire logic [N-1:0] din, // digital input terminals
    input wire logic [N-1:0][lss_pkg::FUNC_W-1:0] func, // function code per terminal
    output lss_pkg::lss_cmd_t cmd // merged speed commands
);

    generate
        if (N < 1 || N > lss_pkg::DATA_W) begin : g_chk
            $error("lss_fdec: terminal count out of range");
        end
    endgenerate

    logic [N-1:0] hit_nom;
    logic [N-1:0] hit_int;
    logic [N-1:0] hit_rel;
    logic [N-1:0] hit_lev;
    logic [N-1:0] hit_insp;
    logic [N-1:0] asg_lev;

    // ==========================================================
    // per-terminal function match
    generate
        for (genvar i = 0; i < N; i++) begin : g_term
            assign hit_nom[i] = din[i] && (func[i] == lss_pkg::FN_NOMINAL);
            assign hit_int[i] = din[i] && (func[i] == lss_pkg::FN_INTER);
            assign hit_rel[i] = din[i] && (func[i] == lss_pkg::FN_RELEV);
            assign hit_lev[i] = din[i] && (func[i] == lss_pkg::FN_LEVEL);
            assign hit_insp[i] = din[i] && (func[i] == lss_pkg::FN_INSP);
            assign asg_lev[i] = (func[i] == lss_pkg::FN_LEVEL);
        end
    endgenerate

    // several terminals may share one code; any of them asserts it
    always_comb begin
        cmd.nom = |hit_nom;
        cmd.inter = |hit_int;
        cmd.relev = |hit_rel;
        cmd.level = |hit_lev;
        cmd.insp = |hit_insp;
        cmd.lev_assigned = |asg_lev;
    end

endmodule

// [src/lss_irq.sv]
`timescale 1ns/10ps
module lss_irq #(
    parameter int W = lss_pkg::IRQ_W
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic [W-1:0] evt, // one-cycle event pulses
    input wire logic [W-1:0] clr, // bits to clear, one-cycle
    input wire logic mask_we, // mask write strobe
    input wire logic [W-1:0] mask_wdata, // new mask
    output logic [W-1:0] stat, // sticky status
    output logic [W-1:0] mask, // mask register
    output logic irq // level interrupt
);

    generate
        if (W < 1 || W > lss_pkg::DATA_W) begin : g_chk
            $error("lss_irq: event width out of range");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] stat;
        logic [W-1:0] mask;
        logic irq;
    } lss_irq_state_t;

    lss_irq_state_t q_r;
    lss_irq_state_t q_nxt;

    // a new event beats a clear in the same cycle
    always_comb begin
        q_nxt = q_r;
        q_nxt.stat = (q_r.stat & ~clr) | evt;
        if (mask_we) begin
            q_nxt.mask = mask_wdata;
        end
        q_nxt.irq = |(q_nxt.stat & q_nxt.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign stat = q_r.stat;
    assign mask = q_r.mask;
    assign irq = q_r.irq;

endmodule

// [src/lss_pkg.sv]
package lss_pkg;

    // ==========================================================
    // widths and counts
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int SPD_W = 16;
    localparam int FUNC_W = 8;
    localparam int N_IN = 5;
    localparam int N_SPD = 7;
    localparam int IRQ_W = 4;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_FUNC0 = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SPD0 = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h044;
    localparam logic [ADDR_W-1:0] REG_STRIDE = 12'h004;

    // ==========================================================
    // control and status fields
    localparam int CTRL_PRIO_LSB = 0;
    localparam int CTRL_PRIO_W = 2;
    localparam int CTRL_RLD_BIT = 4;
    localparam int CTRL_FCLR_BIT = 8;
    localparam logic [CTRL_PRIO_W-1:0] PRIO_HIGH = 2'h1;
    localparam logic RLD_RST = 1'b1;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SEL_LSB = 4;
    localparam int ST_FAULT_BIT = 8;
    localparam int ST_LEVA_BIT = 9;
    localparam int ST_CMD_LSB = 16;

    // ==========================================================
    // input function codes
    localparam logic [FUNC_W-1:0] FN_NOMINAL = 8'h50;
    localparam logic [FUNC_W-1:0] FN_INTER = 8'h51;
    localparam logic [FUNC_W-1:0] FN_RELEV = 8'h52;
    localparam logic [FUNC_W-1:0] FN_LEVEL = 8'h53;
    localparam logic [FUNC_W-1:0] FN_INSP = 8'h54;
    localparam logic [FUNC_W-1:0] FN_NONE = 8'h00;
    localparam logic [N_IN-1:0][FUNC_W-1:0] FUNC_RST =
        {FN_NONE, FN_LEVEL, FN_INTER, FN_INSP, FN_NOMINAL};

    // ==========================================================
    // setpoints, 0.01 Hz per lsb; index order follows lss_sel_t
    typedef enum logic [2:0] {
        SEL_NOM = 3'h0,
        SEL_INT1 = 3'h1,
        SEL_INT2 = 3'h2,
        SEL_INT3 = 3'h3,
        SEL_RELEV = 3'h4,
        SEL_LEVEL = 3'h5,
        SEL_INSP = 3'h6,
        SEL_ZERO = 3'h7
    } lss_sel_t;
    localparam logic [SPD_W-1:0] SPD_NOM_RST = 16'h1388;
    localparam logic [SPD_W-1:0] SPD_LEVEL_RST = 16'h0190;
    localparam logic [SPD_W-1:0] SPD_OTHER_RST = 16'h0000;
    localparam logic [N_SPD-1:0][SPD_W-1:0] SPD_RST = {SPD_OTHER_RST, SPD_LEVEL_RST,
        SPD_OTHER_RST, SPD_OTHER_RST, SPD_OTHER_RST, SPD_OTHER_RST, SPD_NOM_RST};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_LEVEL = 2'b11,
        ST_FAULT = 2'b10
    } lss_state_t;

    // interrupt event bits
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_START = 1;
    localparam int IRQ_LEVEL = 2;
    localparam int IRQ_STOP = 3;

    typedef struct packed {
        logic nom;
        logic inter;
        logic relev;
        logic level;
        logic insp;
        logic lev_assigned;
    } lss_cmd_t;

endpackage

// [src/lss_top.sv]
`timescale 1ns/10ps
// Contract
// - priority select 1 gives six setpoints chosen by separate speed inputs
// - nominal alone picks nominal; intermediate alone picks intermediate one
// - releveling alone picks releveling; intermediate plus releveling picks three
// - intermediate two only via all three commands; three only via combination
// - leveling input assigned: leveling alone picks leveling; nothing gives zero
// - leveling command ignored while any travel command stays active
// - leveling assigned: travel withdrawn means decelerate to leveling speed
// - leveling assigned: stop when leveling or direction command goes away
// - no leveling input: travel withdrawn goes to leveling; direction loss stops
// - no leveling input and no speed input: leveling setpoint is reference
// - no leveling input, detection on, no input at start: reference-loss trip
// - detection bit: 0 off, 1 on, reset 1, used only here
// - inspection speed is never taken as a travel speed here
// - reset function codes 80, 84, 81, 83 on inputs one to four
module lss_top (
    input wire logic pclk, // clock, 250 MHz
    input wire logic presetn, // async reset, active low
    input wire logic [lss_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [lss_pkg::DATA_W-1:0] pwdata, // apb write data
    output logic [lss_pkg::DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [lss_pkg::N_IN-1:0] din, // digital input terminals
    input wire logic dir_up, // up direction command
    input wire logic dir_down, // down direction command
    output logic [lss_pkg::SPD_W-1:0] speed_ref, // speed reference
    output logic run, // drive running
    output logic ref_loss_fault, // reference-loss trip
    output logic irq // interrupt, active high
);

    localparam int AW = lss_pkg::ADDR_W;
    localparam int DW = lss_pkg::DATA_W;
    localparam int NI = lss_pkg::N_IN;
    localparam int NS = lss_pkg::N_SPD;
    localparam int SW = lss_pkg::SPD_W;
    localparam int IW = lss_pkg::IRQ_W;
    localparam int CW = $bits(lss_pkg::lss_cmd_t);

    // sel indexes the setpoint array directly, so every code below SEL_ZERO needs a slot
    generate
        if (NS != int'(lss_pkg::SEL_ZERO) || CW + lss_pkg::ST_CMD_LSB > DW) begin : g_chk
            $error("lss_top: setpoint count does not match the selector");
        end
    endgenerate

    // ==========================================================
    // state
    typedef struct packed {
        logic [lss_pkg::CTRL_PRIO_W-1:0] prio;
        logic rld;
        logic [NI-1:0][lss_pkg::FUNC_W-1:0] func;
        logic [NS-1:0][SW-1:0] spd;
        lss_pkg::lss_state_t st;
        lss_pkg::lss_sel_t sel;
        logic [SW-1:0] sref;
        logic run;
        logic fault;
        logic [DW-1:0] rdata;
        logic err;
    } lss_top_state_t;

    localparam lss_top_state_t TOP_RST = '{
        prio: lss_pkg::PRIO_HIGH,
        rld: lss_pkg::RLD_RST,
        func: lss_pkg::FUNC_RST,
        spd: lss_pkg::SPD_RST,
        st: lss_pkg::ST_IDLE,
        sel: lss_pkg::SEL_ZERO,
        sref: '0,
        run: 1'b0,
        fault: 1'b0,
        rdata: '0,
        err: 1'b0
    };

    lss_top_state_t q_r;
    lss_top_state_t q_nxt;

    lss_pkg::lss_cmd_t cmd;
    lss_pkg::lss_sel_t tsel;
    logic setup;
    logic access;
    logic wr;
    logic hit;
    logic [DW-1:0] rdv;
    logic dir;
    logic travel;
    logic active;
    logic fclr;
    logic [IW-1:0] evt;
    logic [IW-1:0] clr;
    logic mask_we;
    logic [IW-1:0] irq_stat;
    logic [IW-1:0] irq_mask;

    // ==========================================================
    // submodules
    lss_fdec #(
        .N(NI)
    ) u_fdec (
        .din(din),
        .func(q_r.func),
        .cmd(cmd)
    );

    lss_irq #(
        .W(IW)
    ) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .evt(evt),
        .clr(clr),
        .mask_we(mask_we),
        .mask_wdata(pwdata[IW-1:0]),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(irq)
    );

    // ==========================================================
    // apb decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && !q_r.err;

    // read data is captured in the setup cycle so prdata is a flop
    always_comb begin
        rdv = '0;
        hit = 1'b1;
        if (paddr == lss_pkg::OFS_CTRL) begin
            rdv[lss_pkg::CTRL_PRIO_LSB +: lss_pkg::CTRL_PRIO_W] = q_r.prio;
            rdv[lss_pkg::CTRL_RLD_BIT] = q_r.rld;
        end else if (paddr == lss_pkg::OFS_STATUS) begin
            rdv[lss_pkg::ST_STATE_LSB +: 2] = q_r.st;
            rdv[lss_pkg::ST_SEL_LSB +: 3] = q_r.sel;
            rdv[lss_pkg::ST_FAULT_BIT] = q_r.fault;
            rdv[lss_pkg::ST_LEVA_BIT] = cmd.lev_assigned;
            rdv[lss_pkg::ST_CMD_LSB +: CW] = cmd;
        end else if (paddr == lss_pkg::OFS_IRQ_STAT) begin
            rdv[IW-1:0] = irq_stat;
        end else if (paddr == lss_pkg::OFS_IRQ_MASK) begin
            rdv[IW-1:0] = irq_mask;
        end else begin
            hit = 1'b0;
            for (int i = 0; i < NI; i++) begin
                if (paddr == lss_pkg::OFS_FUNC0 + AW'(i) * lss_pkg::REG_STRIDE) begin
                    rdv[lss_pkg::FUNC_W-1:0] = q_r.func[i];
                    hit = 1'b1;
                end
            end
            for (int i = 0; i < NS; i++) begin
                if (paddr == lss_pkg::OFS_SPD0 + AW'(i) * lss_pkg::REG_STRIDE) begin
                    rdv[SW-1:0] = q_r.spd[i];
                    hit = 1'b1;
                end
            end
        end
    end

    // only the bits the reader actually saw are cleared
    assign clr = (access && !pwrite && !q_r.err && paddr == lss_pkg::OFS_IRQ_STAT) ?
        q_r.rdata[IW-1:0] : '0;
    assign mask_we = wr && (paddr == lss_pkg::OFS_IRQ_MASK);
    assign fclr = wr && (paddr == lss_pkg::OFS_CTRL) && pwdata[lss_pkg::CTRL_FCLR_BIT];

    // ==========================================================
    // speed command decode
    assign dir = dir_up || dir_down;
    // inspection is left out of the travel set on purpose
    assign travel = cmd.nom || cmd.inter || cmd.relev;
    assign active = (q_r.prio == lss_pkg::PRIO_HIGH);

    always_comb begin
        case ({cmd.nom, cmd.inter, cmd.relev})
            3'b100: tsel = lss_pkg::SEL_NOM;
            3'b010: tsel = lss_pkg::SEL_INT1;
            3'b111: tsel = lss_pkg::SEL_INT2;
            3'b011: tsel = lss_pkg::SEL_INT3;
            3'b001: tsel = lss_pkg::SEL_RELEV;
            // undefined pairs fall back to the highest speed present
            3'b110: tsel = lss_pkg::SEL_NOM;
            3'b101: tsel = lss_pkg::SEL_NOM;
            default: tsel = lss_pkg::SEL_ZERO;
        endcase
    end

    // ==========================================================
    // sequencer and register writes
    always_comb begin
        q_nxt = q_r;
        evt = '0;
        if (setup) begin
            q_nxt.rdata = rdv;
            q_nxt.err = !hit;
        end
        if (wr) begin
            if (paddr == lss_pkg::OFS_CTRL) begin
                q_nxt.prio = pwdata[lss_pkg::CTRL_PRIO_LSB +: lss_pkg::CTRL_PRIO_W];
                q_nxt.rld = pwdata[lss_pkg::CTRL_RLD_BIT];
            end
            for (int i = 0; i < NI; i++) begin
                if (paddr == lss_pkg::OFS_FUNC0 + AW'(i) * lss_pkg::REG_STRIDE) begin
                    q_nxt.func[i] = pwdata[lss_pkg::FUNC_W-1:0];
                end
            end
            for (int i = 0; i < NS; i++) begin
                if (paddr == lss_pkg::OFS_SPD0 + AW'(i) * lss_pkg::REG_STRIDE) begin
                    q_nxt.spd[i] = pwdata[SW-1:0];
                end
            end
        end
        case (q_r.st)
            lss_pkg::ST_IDLE: begin
                if (active && dir) begin
                    if (!cmd.lev_assigned && q_r.rld && !travel) begin
                        q_nxt.st = lss_pkg::ST_FAULT;
                        evt[lss_pkg::IRQ_FAULT] = 1'b1;
                    end else if (travel) begin
                        q_nxt.st = lss_pkg::ST_RUN;
                        evt[lss_pkg::IRQ_START] = 1'b1;
                    end else if (!cmd.lev_assigned || cmd.level) begin
                        // detection is off here when no leveling input is assigned; leveling runs as travel speed
                        q_nxt.st = lss_pkg::ST_LEVEL;
                        evt[lss_pkg::IRQ_START] = 1'b1;
                    end
                end
            end
            lss_pkg::ST_RUN: begin
                if (!dir || !active) begin
                    q_nxt.st = lss_pkg::ST_IDLE;
                    evt[lss_pkg::IRQ_STOP] = 1'b1;
                end else if (!travel) begin
                    if (cmd.lev_assigned && !cmd.level) begin
                        q_nxt.st = lss_pkg::ST_IDLE;
                        evt[lss_pkg::IRQ_STOP] = 1'b1;
                    end else begin
                        q_nxt.st = lss_pkg::ST_LEVEL;
                        evt[lss_pkg::IRQ_LEVEL] = 1'b1;
                    end
                end
            end
            lss_pkg::ST_LEVEL: begin
                if (!dir || !active || (cmd.lev_assigned && !cmd.level)) begin
                    q_nxt.st = lss_pkg::ST_IDLE;
                    evt[lss_pkg::IRQ_STOP] = 1'b1;
                end else if (travel) begin
                    // a travel command outranks leveling
                    q_nxt.st = lss_pkg::ST_RUN;
                end
            end
            lss_pkg::ST_FAULT: begin
                if (fclr) begin
                    q_nxt.st = lss_pkg::ST_IDLE;
                end
            end
            default: begin
                q_nxt.st = lss_pkg::ST_IDLE;
            end
        endcase

        // reference follows the setpoint register live, even mid-run
        case (q_nxt.st)
            lss_pkg::ST_RUN: q_nxt.sel = tsel;
            lss_pkg::ST_LEVEL: q_nxt.sel = lss_pkg::SEL_LEVEL;
            default: q_nxt.sel = lss_pkg::SEL_ZERO;
        endcase
        if (q_nxt.sel == lss_pkg::SEL_ZERO) begin
            q_nxt.sref = '0;
        end else begin
            q_nxt.sref = q_r.spd[q_nxt.sel];
        end
        q_nxt.run = (q_nxt.st == lss_pkg::ST_RUN) || (q_nxt.st == lss_pkg::ST_LEVEL);
        q_nxt.fault = (q_nxt.st == lss_pkg::ST_FAULT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= TOP_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = q_r.rdata;
    assign pready = access;
    assign pslverr = access && q_r.err;
    assign speed_ref = q_r.sref;
    assign run = q_r.run;
    assign ref_loss_fault = q_r.fault;

endmodule

// [test/lift_speed_select_high_priority_bench.sv]
`timescale 1ns/10ps
module lift_speed_select_high_priority_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic dir_up, dir_down, run, ref_loss_fault, irq;
    logic [lss_pkg::ADDR_W-1:0] paddr;
    logic [lss_pkg::DATA_W-1:0] pwdata, prdata;
    logic [lss_pkg::N_IN-1:0] din;
    logic [lss_pkg::SPD_W-1:0] speed_ref;
    int bad_count;
    int n_tests;

    lss_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .din(din), .dir_up(dir_up),
        .dir_down(dir_down), .speed_ref(speed_ref), .run(run),
        .ref_loss_fault(ref_loss_fault), .irq(irq));
    lss_lift_ctl ctl (.pclk(pclk), .din(din), .dir_up(dir_up), .dir_down(dir_down));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // common tasks
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            bad_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, '0, rd, err);
        chk(rd, exp);
        chk(32'(err), 32'h0000_0000);
    endtask
    // one edge samples the command, the next shows the answer settled
    task automatic go(input logic [4:0] d, input logic up, input logic dn);
        ctl.drive(d, up, dn);
        repeat (2) @(posedge pclk);
        #1;
    endtask
    function automatic logic [11:0] fa(input int i);
        return lss_pkg::OFS_FUNC0 + lss_pkg::REG_STRIDE * 12'(i);
    endfunction
    function automatic logic [11:0] sa(input int i);
        return lss_pkg::OFS_SPD0 + lss_pkg::REG_STRIDE * 12'(i);
    endfunction
    function automatic logic [31:0] sp(input int i);
        return 32'h0000_0100 + 32'(i);
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset_vals();
        logic [4:0][7:0] fexp;
        logic [31:0] rd;
        logic err;
        fexp = {8'h00, 8'h53, 8'h51, 8'h54, 8'h50};
        rdc(lss_pkg::OFS_CTRL, 32'h0000_0011);
        for (int i = 0; i < 5; i++) begin
            rdc(fa(i), 32'(fexp[i]));
        end
        rdc(sa(0), 32'h0000_1388);
        rdc(sa(5), 32'h0000_0190);
        apb(1'b0, 12'h0fc, '0, rd, err);
        chk(rd, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
    endtask
    task automatic t_setup();
        wr(fa(4), 32'(lss_pkg::FN_RELEV));
        for (int i = 0; i < 7; i++) begin
            wr(sa(i), sp(i));
            rdc(sa(i), sp(i));
        end
        wr(lss_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    endtask
    // din: 0 nominal, 1 inspection, 2 intermediate, 3 leveling, 4 releveling
    task automatic t_table();
        logic [4:0] cmb [7] = '{5'b00001, 5'b00100, 5'b10101, 5'b10100, 5'b10000,
            5'b00101, 5'b10001};
        int sel [7] = '{0, 1, 2, 3, 4, 0, 0};
        for (int i = 0; i < 7; i++) begin
            go(cmb[i] | 5'b01000, 1'b1, 1'b0);
            chk(speed_ref, sp(sel[i]));
            go(5'b01000, 1'b1, 1'b0);
            chk(speed_ref, sp(5));
            go(5'b00000, 1'b1, 1'b0);
            chk(run, 0);
            chk(speed_ref, 0);
            go(5'b00000, 1'b0, 1'b0);
        end
        go(5'b01001, 1'b1, 1'b0);
        go(5'b01001, 1'b0, 1'b0);
        chk(run, 0);
        go(5'b01010, 1'b1, 1'b0);
        chk(speed_ref, sp(5));
        go(5'b00000, 1'b0, 1'b0);
    endtask
    task automatic t_irq();
        chk(irq, 0);
        rdc(lss_pkg::OFS_IRQ_STAT, 32'h0000_000e);
        rdc(lss_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        go(5'b00001, 1'b1, 1'b0);
        chk(irq, 0);
        wr(lss_pkg::OFS_IRQ_MASK, 32'h0000_000f);
        rdc(lss_pkg::OFS_IRQ_MASK, 32'h0000_000f);
        chk(irq, 1);
        rdc(lss_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        go(5'b00001, 1'b1, 1'b0);
        chk(irq, 0);
        go(5'b00000, 1'b0, 1'b0);
        chk(irq, 1);
        rdc(lss_pkg::OFS_IRQ_STAT, 32'h0000_0008);
    endtask
    task automatic t_no_leveling();
        wr(fa(3), 32'(lss_pkg::FN_NONE));
        go(5'b00000, 1'b1, 1'b0);
        chk(ref_loss_fault, 1);
        chk(run, 0);
        rdc(lss_pkg::OFS_IRQ_STAT, 32'h0000_0001);
        rdc(lss_pkg::OFS_STATUS, 32'h0000_0172);
        go(5'b00000, 1'b0, 1'b0);
        wr(lss_pkg::OFS_CTRL, 32'h0000_0111);
        go(5'b00000, 1'b0, 1'b0);
        chk(ref_loss_fault, 0);
        wr(lss_pkg::OFS_CTRL, 32'h0000_0001);
        go(5'b00000, 1'b0, 1'b1);
        chk(run, 1);
        chk(speed_ref, sp(5));
        go(5'b00001, 1'b0, 1'b1);
        chk(speed_ref, sp(0));
        wr(sa(0), 32'h0000_0200);
        go(5'b00001, 1'b0, 1'b1);
        chk(speed_ref, 32'h0000_0200);
        wr(sa(0), sp(0));
        go(5'b00000, 1'b0, 1'b1);
        chk(speed_ref, sp(5));
        go(5'b00000, 1'b0, 1'b0);
        chk(run, 0);
        rdc(lss_pkg::OFS_IRQ_STAT, 32'h0000_000e);
    endtask
    task automatic t_prio();
        wr(lss_pkg::OFS_CTRL, 32'h0000_0010);
        go(5'b00001, 1'b1, 1'b0);
        chk(run, 0);
        chk(speed_ref, 0);
        go(5'b00000, 1'b0, 1'b0);
        wr(lss_pkg::OFS_CTRL, 32'h0000_0011);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_setup();
        t_table();
        t_irq();
        t_no_leveling();
        t_prio();
        test_done();
    end
endmodule

// [test/lss_lift_ctl.sv]
`timescale 1ns/10ps
// ==========================================================
// lift controller: speed and direction commands as levels
module lss_lift_ctl (
    input wire logic pclk, // clock
    output logic [lss_pkg::N_IN-1:0] din, // speed command terminals
    output logic dir_up, // up command
    output logic dir_down // down command
);
    initial begin
        din = '0;
        dir_up = 1'b0;
        dir_down = 1'b0;
    end
    // changes only just after an edge, so the block never samples a moving command
    task automatic drive(input logic [lss_pkg::N_IN-1:0] d, input logic up, input logic dn);
        @(posedge pclk);
        din <= d;
        dir_up <= up;
        dir_down <= dn;
    endtask
endmodule

// [test/lss_top_properties.sv]
`timescale 1ns/10ps
module lss_top_properties (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic [lss_pkg::ADDR_W-1:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [lss_pkg::DATA_W-1:0] pwdata, // apb write data
    input wire logic [lss_pkg::DATA_W-1:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [lss_pkg::N_IN-1:0] din, // input terminals
    input wire logic dir_up, // up command
    input wire logic dir_down, // down command
    input wire logic [lss_pkg::SPD_W-1:0] speed_ref, // speed reference
    input wire logic run, // drive running
    input wire logic ref_loss_fault, // reference-loss trip
    input wire logic irq // interrupt
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // sequences
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_no_dir;
        !dir_up && !dir_down;
    endsequence

    // ==========================================================
    // assertions
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_err_access: assert property (pslverr |-> s_access)
        else $error("pslverr outside access phase");
    a_rdata_hold: assert property (s_access |=> $stable(prdata))
        else $error("read data moved after access");
    a_dir_stop: assert property (s_no_dir |=> !run)
        else $error("still running without direction");
    a_stop_zero: assert property (s_no_dir ##1 s_no_dir |-> speed_ref == '0)
        else $error("speed reference not zero when stopped");
    a_fault_norun: assert property (ref_loss_fault |-> !run)
        else $error("running while tripped");
    a_trip_cause: assert property ($rose(ref_loss_fault) |-> $past(dir_up) || $past(dir_down))
        else $error("trip without a start command");
    a_start_cause: assert property ($rose(run) |-> $past(dir_up) || $past(dir_down))
        else $error("start without a direction command");
endmodule

bind lss_top lss_top_properties u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din(din), .dir_up(dir_up), .dir_down(dir_down),
    .speed_ref(speed_ref), .run(run), .ref_loss_fault(ref_loss_fault), .irq(irq));
